/* rtl/serial_link_symbol_transmitter.sv */
// Purpose: transmitter of a block-coded serial link with AHB-Lite control
// Assumes: host strobe and reference clock arrive asynchronously on pins
// Notes:   bit rate comes from a programmable divider standing in for the PLL
// Function
// - 8-bit mode codes bits 7..4 and 3..0 as separate 4-bit groups
// - 9-bit mode forms a 5-bit group 8..4 and 4-bit group 3..0
// - 10-bit mode forms groups 8..4 and bit 9 with bits 3..0
// - symbols go out most significant bit first
// - all-zero command field sends the data symbol
// - nonzero command field sends that command's fixed symbol
// - sync is never host-sent, only padding between user patterns
// - bit rate is ten, eleven or twelve times the byte rate
// - local mode drives the byte clock, or the reference input if ext_ref is set, on the clock output
// - strobe into empty latch goes to second stage, acknowledge rises
// - second stage moves to encoder latch at next byte clock fall
// - first stage is used only while second stage is occupied
// - byte edge shifts stages forward and raises acknowledge unless a strobe parks a pattern in the first stage
// - encoder latch loads at symbol boundary at first chance
// - encoder maps fourteen inputs onto 10, 11 or 12 bits by mode
// - shifter parallel-loads only at a boundary, shifts next bit
// - shifter fills from its low end with repeating sync pattern
`timescale 1ns/1ps
module serial_link_symbol_transmitter
	import symbol_tx_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic [9:0]  data_in,
	input  wire logic [3:0]  command_in,
	input  wire logic        input_strobe,
	input  wire logic        reference_clock_in,
	output logic             ack,
	output logic             clock_out,
	output logic             serial_out
);

	// ---------------- pin synchronisers ----------------
	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_level;

	assign pin_raw = {reference_clock_in, input_strobe};

	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : g_pin
			logic [SYNC_STAGES-1:0] stage;
			logic                   level;
			// a change counts only once the second and third flops agree
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					stage <= '0;
					level <= 1'b0;
				end else if (ce) begin
					stage <= {stage[SYNC_STAGES-2:0], pin_raw[g]};
					if (stage[1] == stage[2])
						level <= stage[2];
				end
			end
			assign pin_level[g] = level;
		end
	endgenerate

	logic strobe_level;
	logic ref_level;
	logic strobe_prev;
	logic strobe_rise;

	assign strobe_level = pin_level[0];
	assign ref_level    = pin_level[1];
	assign strobe_rise  = strobe_level && !strobe_prev;

	// ---------------- registers ----------------
	logic [CTRL_WIDTH-1:0] ctrl;
	logic [7:0]            bit_div;
	logic                  wr_pend;
	logic [7:0]            wr_addr;
	logic                  addr_ok;
	logic                  rd_take;
	logic                  wr_ctrl;
	logic                  wr_div;
	logic [CTRL_WIDTH-1:0] next_ctrl;
	logic [7:0]            next_bit_div;
	logic [31:0]           rd_value;

	assign addr_ok      = hsel && htrans[1] && hready;
	assign rd_take      = addr_ok && !hwrite;
	assign wr_ctrl      = wr_pend && (wr_addr == ADDR_CTRL);
	assign wr_div       = wr_pend && (wr_addr == ADDR_BIT_DIV);
	assign next_ctrl    = wr_ctrl ? hwdata[CTRL_WIDTH-1:0] : ctrl;
	assign next_bit_div = wr_div ? hwdata[7:0] : bit_div;

	logic [1:0]  mode;
	logic        local_mode;
	logic        ext_ref;

	assign mode       = ctrl[CTRL_MODE_LSB +: 2];
	assign local_mode = ctrl[CTRL_LOCAL_BIT];
	assign ext_ref    = ctrl[CTRL_EXTREF_BIT];

	// ---------------- input latch state ----------------
	logic [13:0] stage1;
	logic [13:0] stage2;
	logic [13:0] enc_latch;
	logic        stage1_full;
	logic        stage2_full;
	logic        enc_full;

	// read path sees data-phase writes so back-to-back access is coherent
	always_comb begin
		case (haddr[7:0])
			ADDR_CTRL:    rd_value = {{(32-CTRL_WIDTH){1'b0}}, next_ctrl};
			ADDR_BIT_DIV: rd_value = {24'h000000, next_bit_div};
			ADDR_STATUS:  rd_value = {28'h0000000, enc_full, stage1_full, stage2_full, ack};
			default:      rd_value = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			ctrl      <= CTRL_RESET;
			bit_div   <= BIT_DIV_RESET;
		end else if (ce) begin
			hreadyout <= 1'b1;
			wr_pend   <= addr_ok && hwrite;
			wr_addr   <= haddr[7:0];
			ctrl      <= next_ctrl;
			bit_div   <= next_bit_div;
			if (rd_take)
				hrdata <= rd_value;
		end
	end

	// ---------------- bit and byte timing ----------------
	logic [7:0]  div_cnt;
	logic        bit_tick;
	logic [3:0]  symbol_bits;
	logic [11:0] sync_symbol;
	logic        boundary;
	logic [3:0]  bit_index;
	logic        line_bit;
	logic        byte_high;

	assign bit_tick = (div_cnt >= bit_div);

	always_comb begin
		case (mode)
			MODE_9: begin
				symbol_bits = SYMBOL_BITS_9;
				sync_symbol = SYNC_SYMBOL_9BIT;
			end
			MODE_10: begin
				symbol_bits = SYMBOL_BITS_10;
				sync_symbol = SYNC_SYMBOL_10BIT;
			end
			default: begin
				symbol_bits = SYMBOL_BITS_8;
				sync_symbol = SYNC_SYMBOL_8BIT;
			end
		endcase
	end

	// internal byte clock is high in the second half so it falls at the boundary
	assign byte_high = (bit_index >= {1'b0, symbol_bits[3:1]});

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_cnt <= 8'h00;
		else if (ce)
			div_cnt <= bit_tick ? 8'h00 : div_cnt + 8'h01;
	end

	// ---------------- input latch and encoder latch ----------------
	logic [13:0] pattern;
	logic        moved_s2_full;
	logic [13:0] moved_s2;
	logic        to_stage2;
	logic        to_stage1;
	logic        take;

	assign pattern       = {command_in, data_in};
	assign take          = boundary && stage2_full;
	assign moved_s2_full = boundary ? stage1_full : stage2_full;
	assign moved_s2      = boundary ? stage1 : stage2;
	assign to_stage2     = strobe_rise && !moved_s2_full;
	assign to_stage1     = strobe_rise && moved_s2_full;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strobe_prev <= 1'b0;
			stage1      <= 14'h0000;
			stage2      <= 14'h0000;
			stage1_full <= 1'b0;
			stage2_full <= 1'b0;
			enc_latch   <= 14'h0000;
			enc_full    <= 1'b0;
			ack         <= ACK_RESET;
		end else if (ce) begin
			strobe_prev <= strobe_level;
			if (boundary) begin
				enc_full <= stage2_full;
				if (stage2_full)
					enc_latch <= stage2;
			end
			stage2      <= to_stage2 ? pattern : moved_s2;
			stage2_full <= to_stage2 || moved_s2_full;
			// a repeat strobe in one byte simply overwrites the first stage
			if (to_stage1)
				stage1 <= pattern;
			stage1_full <= to_stage1 || (stage1_full && !boundary);
			// a pattern newly parked in stage one keeps acknowledge low even at a byte edge
			if (to_stage1)
				ack <= 1'b0;
			else if (to_stage2 || (boundary && stage1_full))
				ack <= 1'b1;
		end
	end

	// ---------------- encoder and shifter ----------------
	logic [11:0] enc_symbol;

	symbol_encoder u_encoder (
		.mode    (mode),
		.data    (enc_latch[9:0]),
		.command (enc_latch[13:10]),
		.symbol  (enc_symbol)
	);

	symbol_shifter u_shifter (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.ce          (ce),
		.bit_tick    (bit_tick),
		.symbol_bits (symbol_bits),
		.sync_symbol (sync_symbol),
		.load_valid  (enc_full),
		.load_symbol (enc_symbol),
		.line_bit    (line_bit),
		.boundary    (boundary),
		.bit_index   (bit_index)
	);

	// ---------------- pin outputs ----------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_out <= 1'b0;
			clock_out  <= 1'b0;
		end else if (ce) begin
			serial_out <= line_bit;
			if (local_mode)
				clock_out <= ext_ref ? ref_level : byte_high;
			else
				clock_out <= 1'b0;
		end
	end

endmodule

/* rtl/symbol_encoder.sv */
// Purpose: maps a latched pattern onto a data or command symbol
// Assumes: pattern is stable while the shifter loads it
// Notes:   purely combinational; result right-justified in 12 bits
`timescale 1ns/1ps
module symbol_encoder
	import symbol_tx_pkg::*;
(
	input  wire logic [1:0]  mode,
	input  wire logic [9:0]  data,
	input  wire logic [3:0]  command,
	output logic      [11:0] symbol
);

	function automatic logic [4:0] code4(input logic [3:0] v);
		case (v)
			4'h0: code4 = 5'h1E;
			4'h1: code4 = 5'h09;
			4'h2: code4 = 5'h14;
			4'h3: code4 = 5'h15;
			4'h4: code4 = 5'h0A;
			4'h5: code4 = 5'h0B;
			4'h6: code4 = 5'h0E;
			4'h7: code4 = 5'h0F;
			4'h8: code4 = 5'h12;
			4'h9: code4 = 5'h13;
			4'hA: code4 = 5'h16;
			4'hB: code4 = 5'h17;
			4'hC: code4 = 5'h1A;
			4'hD: code4 = 5'h1B;
			4'hE: code4 = 5'h1C;
			default: code4 = 5'h1D;
		endcase
	endfunction

	function automatic logic [5:0] code5(input logic [4:0] v);
		case (v)
			5'h00: code5 = 6'h36;
			5'h01: code5 = 6'h11;
			5'h02: code5 = 6'h24;
			5'h03: code5 = 6'h25;
			5'h04: code5 = 6'h12;
			5'h05: code5 = 6'h13;
			5'h06: code5 = 6'h16;
			5'h07: code5 = 6'h17;
			5'h08: code5 = 6'h22;
			5'h09: code5 = 6'h31;
			5'h0A: code5 = 6'h37;
			5'h0B: code5 = 6'h27;
			5'h0C: code5 = 6'h32;
			5'h0D: code5 = 6'h33;
			5'h0E: code5 = 6'h34;
			5'h0F: code5 = 6'h35;
			5'h10: code5 = 6'h3E;
			5'h11: code5 = 6'h19;
			5'h12: code5 = 6'h29;
			5'h13: code5 = 6'h2D;
			5'h14: code5 = 6'h1A;
			5'h15: code5 = 6'h1B;
			5'h16: code5 = 6'h1E;
			5'h17: code5 = 6'h1F;
			5'h18: code5 = 6'h2A;
			5'h19: code5 = 6'h2B;
			5'h1A: code5 = 6'h2E;
			5'h1B: code5 = 6'h2F;
			5'h1C: code5 = 6'h3A;
			5'h1D: code5 = 6'h3B;
			5'h1E: code5 = 6'h3C;
			default: code5 = 6'h3D;
		endcase
	endfunction

	logic [11:0] data_8;
	logic [11:0] data_9;
	logic [11:0] data_10;
	logic [11:0] cmd_8;
	logic [11:0] cmd_9;
	logic [11:0] cmd_10;

	assign data_8  = {2'h0, code4(data[7:4]), code4(data[3:0])};
	assign data_9  = {1'h0, code5(data[8:4]), code4(data[3:0])};
	assign data_10 = {code5(data[8:4]), code5({data[9], data[3:0]})};

	always_comb begin
		case (command)
			4'h1: cmd_8 = 12'h3FF;
			4'h2: cmd_8 = 12'h1AD;
			4'h3: cmd_8 = 12'h1B9;
			4'h4: cmd_8 = 12'h3E4;
			4'h5: cmd_8 = 12'h1A7;
			4'h6: cmd_8 = 12'h327;
			4'h7: cmd_8 = 12'h339;
			4'h8: cmd_8 = 12'h084;
			4'h9: cmd_8 = 12'h09F;
			4'hA: cmd_8 = 12'h080;
			4'hB: cmd_8 = 12'h0E7;
			4'hC: cmd_8 = 12'h0F9;
			4'hD: cmd_8 = 12'h004;
			4'hE: cmd_8 = 12'h01F;
			default: cmd_8 = 12'h000;
		endcase
		case (command[2:0])
			3'h1: cmd_9 = 12'h7FF;
			3'h2: cmd_9 = 12'h3AD;
			3'h3: cmd_9 = 12'h3B9;
			3'h4: cmd_9 = 12'h7E4;
			3'h5: cmd_9 = 12'h3A7;
			3'h6: cmd_9 = 12'h727;
			default: cmd_9 = 12'h739;
		endcase
		case (command[1:0])
			2'h1: cmd_10 = 12'hFFF;
			2'h2: cmd_10 = 12'h75D;
			default: cmd_10 = 12'h779;
		endcase
	end

	// only the command lines of the active mode count; the unused upper command lines are ignored
	always_comb begin
		case (mode)
			MODE_9:  symbol = (command[2:0] == 3'h0) ? data_9 : cmd_9;
			MODE_10: symbol = (command[1:0] == 2'h0) ? data_10 : cmd_10;
			default: symbol = (command == 4'h0) ? data_8 : cmd_8;
		endcase
	end

endmodule

/* rtl/symbol_shifter.sv */
// Purpose: symbol shifter with sync fill and bit counter
// Assumes: bit_tick is a one-cycle pulse per serial bit
// Notes:   boundary marks the last bit of each symbol
`timescale 1ns/1ps
module symbol_shifter
	import symbol_tx_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        bit_tick,
	input  wire logic [3:0]  symbol_bits,
	input  wire logic [11:0] sync_symbol,
	input  wire logic        load_valid,
	input  wire logic [11:0] load_symbol,
	output logic             line_bit,
	output logic             boundary,
	output logic      [3:0]  bit_index
);

	logic [11:0] shift_reg;
	logic [3:0]  last_index;
	logic [3:0]  sync_pos;
	logic        sync_bit;

	assign last_index = symbol_bits - 4'h1;
	assign boundary   = bit_tick && (bit_index >= last_index);
	assign sync_pos   = last_index - bit_index;
	// the fill walks the sync symbol so a full unloaded symbol is sync
	assign sync_bit   = sync_symbol[sync_pos];
	assign line_bit   = shift_reg[last_index];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_reg <= 12'h000;
			bit_index <= 4'h0;
		end else if (ce && bit_tick) begin
			bit_index <= boundary ? 4'h0 : bit_index + 4'h1;
			if (boundary && load_valid)
				shift_reg <= load_symbol;
			else
				shift_reg <= {shift_reg[10:0], sync_bit};
		end
	end

endmodule

/* rtl/symbol_tx_pkg.sv */
// Purpose: shared constants for the serial link symbol transmitter
// Assumes: 32-bit AHB-Lite register bus, one clock hclk
// Notes:   symbols are held right-justified in 12 bits
package symbol_tx_pkg;

	// register byte addresses
	localparam logic [7:0]  ADDR_CTRL        = 8'h00;
	localparam logic [7:0]  ADDR_BIT_DIV     = 8'h04;
	localparam logic [7:0]  ADDR_STATUS      = 8'h08;

	// control fields
	localparam int          CTRL_MODE_LSB    = 0;
	localparam int          CTRL_LOCAL_BIT   = 2;
	localparam int          CTRL_EXTREF_BIT  = 3;
	localparam int          CTRL_WIDTH       = 4;
	localparam logic [3:0]  CTRL_RESET       = 4'h4;
	localparam logic [7:0]  BIT_DIV_RESET    = 8'h01;
	localparam logic        ACK_RESET        = 1'b1;

	// width modes
	localparam logic [1:0]  MODE_8           = 2'h0;
	localparam logic [1:0]  MODE_9           = 2'h1;
	localparam logic [1:0]  MODE_10          = 2'h2;

	// bits per symbol, the bit-rate multiple of the byte rate
	localparam logic [3:0]  SYMBOL_BITS_8    = 4'hA;
	localparam logic [3:0]  SYMBOL_BITS_9    = 4'hB;
	localparam logic [3:0]  SYMBOL_BITS_10   = 4'hC;

	// sync symbols, right-justified
	localparam logic [11:0] SYNC_SYMBOL_8BIT  = 12'h311;
	localparam logic [11:0] SYNC_SYMBOL_9BIT  = 12'h311;
	localparam logic [11:0] SYNC_SYMBOL_10BIT = 12'h623;

	// pin synchroniser depth
	localparam int          SYNC_STAGES      = 3;
	localparam int          PIN_COUNT        = 2;

endpackage

/* testbench/host_pattern_model.sv */
// Purpose: host logic driving the parallel pattern port
// Assumes: one request at a time, given while busy is low
// Notes:   released pattern pins show the inverse of the last value
`timescale 1ns/1ps
module host_pattern_model (
	input  wire logic       hclk,
	input  wire logic       req,
	input  wire logic [9:0] req_data,
	input  wire logic [3:0] req_cmd,
	input  wire logic       ack,
	output logic      [9:0] data_in,
	output logic      [3:0] command_in,
	output logic            input_strobe,
	output logic            busy
);
	int n;
	initial begin
		data_in = 10'h000;
		command_in = 4'h0;
		input_strobe = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge hclk);
			if (req) begin
				busy <= 1'b1;
				n = 0;
				// a strobe into a full first stage would overwrite it
				while (ack !== 1'b1 && n < 400) begin
					@(posedge hclk);
					n++;
				end
				data_in <= req_data;
				command_in <= req_cmd;
				@(posedge hclk);
				input_strobe <= 1'b1;
				repeat (7) @(posedge hclk);
				input_strobe <= 1'b0;
				repeat (4) @(posedge hclk);
				data_in <= ~req_data;
				command_in <= ~req_cmd;
				busy <= 1'b0;
			end
		end
	end
endmodule

/* testbench/symbol_tx_assertions.sv */
// Purpose: port-level checks of the symbol transmitter
// Assumes: control fields change only through bus writes
// Notes:   ctrl and bit divider are snooped from the bus
`timescale 1ns/1ps
module symbol_tx_assertions
	import symbol_tx_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        ce,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        input_strobe,
	input wire logic        ack,
	input wire logic        clock_out,
	input wire logic        serial_out
);
	logic       wr_pend;
	logic [7:0] wr_addr;
	logic [3:0] ctrl_q;
	logic [7:0] div_q;
	wire        rd_take = hsel & htrans[1] & ~hwrite & hready & ce;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			ctrl_q  <= CTRL_RESET;
			div_q   <= BIT_DIV_RESET;
		end else if (ce) begin
			if (wr_pend && wr_addr == ADDR_CTRL) ctrl_q <= hwdata[3:0];
			if (wr_pend && wr_addr == ADDR_BIT_DIV) div_q <= hwdata[7:0];
			wr_pend <= hsel & htrans[1] & hwrite & hready;
			wr_addr <= haddr[7:0];
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response on the bus");
	a_ready_kept: assert property ($rose(hreadyout) |=> hreadyout [*8])
		else $error("wait state inserted");
	a_rdata_cause: assert property ($changed(hrdata) |-> $past(rd_take))
		else $error("read data changed without a read");
	a_ce_freeze: assert property (!ce |=> $stable(serial_out) && $stable(ack) && $stable(clock_out))
		else $error("outputs moved while clock enable low");
	a_ack_drop: assert property ($fell(ack) |-> $past(input_strobe, 2))
		else $error("acknowledge fell without a strobe");
	a_ack_return: assert property ($fell(ack) |-> ##[1:150] ack)
		else $error("acknowledge not restored at a byte edge");
	a_clkout_off: assert property (!ctrl_q[CTRL_LOCAL_BIT] [*3] |-> clock_out == 1'b0)
		else $error("clock output driven outside local mode");
	// a divider write may cut the bit in flight, so that cycle is excused
	a_bit_hold: assert property ($changed(serial_out) && div_q != 8'h00 |=>
		$stable(serial_out) || $changed(div_q))
		else $error("serial bit shorter than the divider");
endmodule

bind serial_link_symbol_transmitter symbol_tx_assertions u_chk (.hclk, .hresetn, .ce, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .input_strobe,
	.ack, .clock_out, .serial_out);

/* testbench/test_serial_link_symbol_transmitter.sv */
// Purpose: self-checking bench for the serial link symbol transmitter
// Assumes: host patterns go through the host model one at a time
// Notes:   line symbols are framed by locking onto the sync padding
`timescale 1ns/1ps
module test_serial_link_symbol_transmitter
	import symbol_tx_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        ce = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        refclk = 1'b0;
	logic        req = 1'b0;
	logic [9:0]  req_data = 10'h000;
	logic [3:0]  req_cmd = 4'h0;
	wire         hreadyout, hresp, ack, clock_out, serial_out, input_strobe, busy;
	wire  [31:0] hrdata;
	wire  [9:0]  data_in;
	wire  [3:0]  command_in;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	int          cnt = 0;
	int          nbit = 0;
	int          nb = 0;
	int          ctog = 0;
	logic        pco = 1'b0;
	logic [11:0] exp_q[$];
	logic [31:0] rd_q[$];
	logic [1:0]  mode_v = MODE_8;
	logic [7:0]  div_v = BIT_DIV_RESET;
	logic [11:0] sync_v = SYNC_SYMBOL_8BIT;
	logic [11:0] win = 12'h000;
	logic [11:0] msk = 12'h000;
	logic        locked = 1'b0;
	logic        prev_bit = 1'b0;
	logic        dp_rd = 1'b0;
	logic [7:0]  t5[16] = '{8'h1E, 8'h09, 8'h14, 8'h15, 8'h0A, 8'h0B, 8'h0E, 8'h0F,
		8'h12, 8'h13, 8'h16, 8'h17, 8'h1A, 8'h1B, 8'h1C, 8'h1D};
	logic [7:0]  t6[32] = '{8'h36, 8'h11, 8'h24, 8'h25, 8'h12, 8'h13, 8'h16, 8'h17,
		8'h22, 8'h31, 8'h37, 8'h27, 8'h32, 8'h33, 8'h34, 8'h35, 8'h3E, 8'h19, 8'h29, 8'h2D,
		8'h1A, 8'h1B, 8'h1E, 8'h1F, 8'h2A, 8'h2B, 8'h2E, 8'h2F, 8'h3A, 8'h3B, 8'h3C, 8'h3D};
	// command symbols: 8-bit codes 1..F, then 9-bit 1..7, then 10-bit 1..3
	logic [11:0] cmd_tab[25] = '{12'h3FF, 12'h1AD, 12'h1B9, 12'h3E4, 12'h1A7, 12'h327,
		12'h339, 12'h084, 12'h09F, 12'h080, 12'h0E7, 12'h0F9, 12'h004, 12'h01F, 12'h000,
		12'h7FF, 12'h3AD, 12'h3B9, 12'h7E4, 12'h3A7, 12'h727, 12'h739, 12'hFFF, 12'h75D, 12'h779};

	always #25 hclk = ~hclk;
	always #37 refclk = ~refclk;

	serial_link_symbol_transmitter DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.data_in(data_in), .command_in(command_in), .input_strobe(input_strobe),
		.reference_clock_in(refclk), .ack(ack), .clock_out(clock_out), .serial_out(serial_out));

	host_pattern_model u_host (.hclk(hclk), .req(req), .req_data(req_data), .req_cmd(req_cmd),
		.ack(ack), .data_in(data_in), .command_in(command_in), .input_strobe(input_strobe),
		.busy(busy));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
		input logic [31:0] e);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		if (!w) rd_q.push_back(e);
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	function automatic logic [11:0] dsym(input logic [9:0] d);
		case (mode_v)
			MODE_9:  return {1'b0, t6[d[8:4]][5:0], t5[d[3:0]][4:0]};
			MODE_10: return {t6[d[8:4]][5:0], t6[{d[9], d[3:0]}][5:0]};
			default: return {2'b00, t5[d[7:4]][4:0], t5[d[3:0]][4:0]};
		endcase
	endfunction

	// unused command pins get random values: the encoder must ignore them
	task automatic send(input logic [9:0] d, input logic [3:0] c);
		logic [3:0] cw;
		cw = (mode_v == MODE_9) ? {1'($urandom), c[2:0]} :
			(mode_v == MODE_10) ? {2'($urandom), c[1:0]} : c;
		if (c == 4'h0)
			exp_q.push_back(dsym(d));
		else
			exp_q.push_back(cmd_tab[c - 1 + (mode_v == MODE_9 ? 15 : mode_v == MODE_10 ? 22 : 0)]);
		req_data <= d;
		req_cmd <= cw;
		req <= 1'b1;
		@(posedge hclk);
		req <= 1'b0;
		do @(posedge hclk); while (busy === 1'b1);
	endtask

	// mode 3 runs as 8-bit with local mode off; 10-bit uses the external reference
	task automatic cfg(input logic [1:0] m, input logic [7:0] dv);
		logic [3:0] c;
		c = {m == MODE_10, m != 2'h3, m};
		locked = 1'b0;
		nb = 0;
		bus(ADDR_CTRL, 1'b1, {28'h0, c}, 32'h0);
		bus(ADDR_BIT_DIV, 1'b1, {24'h0, dv}, 32'h0);
		bus(ADDR_CTRL, 1'b0, 32'h0, {28'h0, c});
		repeat (80) @(posedge hclk);
		mode_v = (m == 2'h3) ? MODE_8 : m;
		sync_v = mode_v == MODE_10 ? SYNC_SYMBOL_10BIT :
			mode_v == MODE_9 ? SYNC_SYMBOL_9BIT : SYNC_SYMBOL_8BIT;
		div_v = dv;
		nb = 10 + mode_v;
		ctog = 0;
		repeat (150) @(posedge hclk);
		chk("sync lock", 32'h1, {31'h0, locked});
		chk("clock_out toggling", {31'h0, m != 2'h3}, {31'h0, ctog > 2});
	endtask

	always @(posedge hclk) begin
		if (dp_rd && hreadyout === 1'b1) chk("hrdata", rd_q.pop_front(), hrdata);
		dp_rd <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
	end

	// frozen while ce is low, so bit timing survives a freeze
	always @(posedge hclk) if (hresetn && ce) begin
		msk = 12'hFFF >> (12 - nb);
		cnt = (serial_out !== prev_bit || cnt >= div_v) ? 0 : cnt + 1;
		prev_bit = serial_out;
		if (cnt == div_v / 2) begin
			win = {win[10:0], serial_out};
			nbit++;
			if (!locked && (win & msk) === sync_v) begin
				locked = 1'b1;
				nbit = 0;
			end else if (locked && nbit == nb) begin
				nbit = 0;
				if ((win & msk) !== sync_v) begin
					if (exp_q.size() == 0) chk("unexpected symbol", 32'h0, 32'(win & msk));
					else chk("symbol", 32'(exp_q.pop_front()), 32'(win & msk));
				end
			end
		end
	end

	always @(posedge hclk) begin
		if (clock_out !== pco)
			ctog++;
		pco = clock_out;
	end

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		void'($urandom(53));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(ADDR_CTRL, 1'b0, 32'h0, {28'h0, CTRL_RESET});
		bus(ADDR_BIT_DIV, 1'b0, 32'h0, {24'h0, BIT_DIV_RESET});
		bus(ADDR_STATUS, 1'b1, 32'hF, 32'h0);
		bus(ADDR_STATUS, 1'b0, 32'h0, {31'h0, ACK_RESET});
		bus(8'h0C, 1'b0, 32'h0, 32'h0);
		for (int m = 0; m < 4; m++) begin
			cfg(2'(m), 8'(m));
			// commands are spaced by data so none repeats back to back
			for (int c = 0; c < (1 << (4 - mode_v)); c++) begin
				send(10'($urandom), 4'h0);
				if (c > 0) send(10'($urandom), 4'(c));
			end
			ce <= 1'b0;
			repeat (3) @(posedge hclk);
			ce <= 1'b1;
			for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge hclk);
			chk("pending symbols", 32'h0, 32'(exp_q.size()));
			bus(ADDR_STATUS, 1'b0, 32'h0, 32'h1);
		end
		summarize();
	end
endmodule
